// [src/pubs_boot.sv]
`timescale 1ns/100ps
`include "pubs_defs.svh"

module pubs_boot
   import pubs_pkg::*;
#(
   parameter int WIDE_SEL = 1,
   parameter int VARIANT = 2,
   parameter int FIFO_DEPTH = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Boot straps
   input wire logic [1:0] boot_select_pins,
   input wire logic [2:0] boot_select_pins_wide,
   input wire logic [1:0] spi_slave_kind,
   input wire logic mp_boot_en,
   input wire logic [2:0] proc_id,
   // Boot stream from the selected source
   input wire logic stream_valid,
   output logic stream_ready,
   input wire logic [47:0] stream_data,
   // Internal memory write port
   output logic mem_wr_en,
   output logic [19:0] mem_wr_addr,
   output logic [47:0] mem_wr_data,
   // Boot status and core control
   output logic [2:0] boot_mode,
   output logic [8:0] dma_count,
   output logic dma_wide,
   output logic [1:0] spi_addr_len,
   output logic [31:0] spi_cmd_word,
   output logic vector_table_internal,
   output logic rom_fetch,
   output logic peripheral_routing_en,
   output logic core_start,
   output logic [19:0] core_pc,
   output logic boot_done
);

   // ----------------------------------------------------------------------
   // Variant constants
   // ----------------------------------------------------------------------
   localparam logic [19:0] BASE = (VARIANT == 0) ? `PUBS_BASE_V0 :
                                  (VARIANT == 1) ? `PUBS_BASE_V1 : `PUBS_BASE_V2;

   // ----------------------------------------------------------------------
   // Stream buffer
   // ----------------------------------------------------------------------
   logic f_valid;
   logic f_ready;
   logic [47:0] f_data;

   pubs_fifo #(
      .WIDTH(48),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .nrst(nrst),
      .in_valid(stream_valid),
      .in_ready(stream_ready),
      .in_data(stream_data),
      .out_valid(f_valid),
      .out_ready(f_ready),
      .out_data(f_data)
   );

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   pubs_state_t state_r, state_nxt;
   pubs_mode_t mode_r, mode_nxt;
   logic [8:0] dcnt_r, dcnt_nxt;
   logic wide_r, wide_nxt;
   logic [1:0] phase_r, phase_nxt;
   logic [15:0] hold_r, hold_nxt;
   logic [31:0] low_r, low_nxt;
   logic [15:0] acnt_r, acnt_nxt;
   logic skip_r, skip_nxt;
   logic drop_r, drop_nxt;
   logic mp_r, mp_nxt;
   logic [2:0] id_r, id_nxt;
   logic [19:0] addr_r, addr_nxt;
   logic we_r, we_nxt;
   logic [19:0] waddr_r, waddr_nxt;
   logic [47:0] wdata_r, wdata_nxt;
   logic [1:0] alen_r, alen_nxt;
   logic [31:0] cmd_r, cmd_nxt;
   logic vti_r, vti_nxt;
   logic rom_r, rom_nxt;
   logic pre_r, pre_nxt;
   logic start_r, start_nxt;
   logic [19:0] pc_r, pc_nxt;
   logic done_r, done_nxt;

   logic [2:0] sel;
   logic consume;
   logic emit;
   logic [47:0] word48;
   logic [31:0] w32;
   logic [15:0] hdr_cnt;
   logic [2:0] hdr_id;

   // ----------------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      mode_nxt = mode_r;
      dcnt_nxt = dcnt_r;
      wide_nxt = wide_r;
      phase_nxt = phase_r;
      hold_nxt = hold_r;
      low_nxt = low_r;
      acnt_nxt = acnt_r;
      skip_nxt = skip_r;
      drop_nxt = drop_r;
      mp_nxt = mp_r;
      id_nxt = id_r;
      addr_nxt = addr_r;
      we_nxt = 1'b0;
      waddr_nxt = waddr_r;
      wdata_nxt = wdata_r;
      alen_nxt = alen_r;
      cmd_nxt = cmd_r;
      vti_nxt = vti_r;
      rom_nxt = rom_r;
      pre_nxt = pre_r;
      start_nxt = 1'b0;
      pc_nxt = pc_r;
      done_nxt = done_r;
      sel = (WIDE_SEL != 0) ? boot_select_pins_wide : {1'b0, boot_select_pins};
      f_ready = (state_r == PUBS_S_KERNEL) | (state_r == PUBS_S_APP_HDR) |
                (state_r == PUBS_S_APP_DATA);
      consume = f_valid & f_ready;
      w32 = f_data[31:0];
      hdr_cnt = w32[`PUBS_HDR_CNT_MSB:`PUBS_HDR_CNT_LSB];
      hdr_id = w32[`PUBS_HDR_ID_MSB:`PUBS_HDR_ID_LSB];
      emit = 1'b0;
      word48 = f_data;

      // Three 32-bit words pack into two 48-bit words, least significant first.
      if (consume & ~drop_r & (state_r != PUBS_S_APP_HDR)) begin
         if (wide_r) begin
            emit = 1'b1;
         end else begin
            unique case (phase_r)
               2'h0: begin
                  low_nxt = w32;
                  phase_nxt = 2'h1;
               end
               2'h1: begin
                  emit = 1'b1;
                  word48 = {w32[15:0], low_r};
                  hold_nxt = w32[31:16];
                  phase_nxt = 2'h2;
               end
               default: begin
                  emit = 1'b1;
                  word48 = {w32, hold_r};
                  phase_nxt = 2'h0;
               end
            endcase
         end
      end

      // Kernel words land in block 0 from the base upward.
      // Writes come first so the rewind to the base at kernel end wins over the increment.
      if (emit & ~((state_r == PUBS_S_APP_DATA) & skip_r)) begin
         we_nxt = 1'b1;
         waddr_nxt = addr_r;
         wdata_nxt = word48;
         addr_nxt = 20'(addr_r + 1'b1);
      end

      unique case (state_r)
         PUBS_S_SAMPLE: begin
            // Straps are taken only here, so pin changes after this are ignored.
            mp_nxt = mp_boot_en;
            id_nxt = proc_id;
            addr_nxt = BASE;
            phase_nxt = 2'h0;
            unique case (sel)
               `PUBS_SEL_SPI_SLAVE: mode_nxt = PUBS_M_SPI_SLAVE;
               `PUBS_SEL_SPI_MASTER: mode_nxt = PUBS_M_SPI_MASTER;
               `PUBS_SEL_PROM: mode_nxt = PUBS_M_PROM;
               `PUBS_SEL_LINK0: mode_nxt = PUBS_M_LINK;
               default: mode_nxt = PUBS_M_NONE;
            endcase
            if (mode_nxt == PUBS_M_NONE) begin
               // Straight to ROM; no kernel and the vector table stays in ROM.
               rom_nxt = 1'b1;
               vti_nxt = 1'b0;
               pc_nxt = `PUBS_ROM_VEC;
               start_nxt = 1'b1;
               done_nxt = 1'b1;
               state_nxt = PUBS_S_RUN;
            end else begin
               vti_nxt = 1'b1;
               wide_nxt = (mode_nxt == PUBS_M_LINK);
               dcnt_nxt = wide_nxt ? `PUBS_KERN_CNT48 : `PUBS_KERN_CNT32;
               state_nxt = PUBS_S_KERNEL;
            end
            if (mode_nxt == PUBS_M_SPI_MASTER) begin
               // The word shifted in while the read command goes out is junk.
               drop_nxt = 1'b1;
               cmd_nxt = `PUBS_SPI_RD_CMD;
               unique case (spi_slave_kind)
                  PUBS_K_ADDR16: alen_nxt = `PUBS_SPI_ALEN_16;
                  PUBS_K_ADDR24: alen_nxt = `PUBS_SPI_ALEN_24;
                  default: alen_nxt = `PUBS_SPI_ALEN_NONE;
               endcase
            end
         end
         PUBS_S_KERNEL: begin
            if (consume) begin
               if (drop_r) begin
                  drop_nxt = 1'b0;
               end else begin
                  dcnt_nxt = 9'(dcnt_r - 1'b1);
                  if (dcnt_r == 9'h001) begin
                     // Application restarts at the base and overwrites the kernel.
                     addr_nxt = BASE;
                     state_nxt = PUBS_S_APP_HDR;
                  end
               end
            end
         end
         PUBS_S_APP_HDR: begin
            if (consume) begin
               phase_nxt = 2'h0;
               if (hdr_cnt == 16'h0000) begin
                  state_nxt = PUBS_S_START;
               end else begin
                  acnt_nxt = hdr_cnt;
                  // In multiprocessor PROM boot, other processors' images are read through but not stored.
                  skip_nxt = mp_r & (mode_r == PUBS_M_PROM) & (hdr_id != id_r);
                  state_nxt = PUBS_S_APP_DATA;
               end
            end
         end
         PUBS_S_APP_DATA: begin
            if (emit) begin
               acnt_nxt = 16'(acnt_r - 1'b1);
               if (acnt_r == 16'h0001) begin
                  state_nxt = PUBS_S_APP_HDR;
               end
            end
         end
         PUBS_S_START: begin
            pc_nxt = 20'(BASE + `PUBS_VEC_OFF);
            start_nxt = 1'b1;
            done_nxt = 1'b1;
            state_nxt = PUBS_S_RUN;
         end
         PUBS_S_RUN: begin
            state_nxt = PUBS_S_RUN;
         end
         default: begin
            state_nxt = PUBS_S_SAMPLE;
         end
      endcase

   end

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_r <= PUBS_S_SAMPLE;
         mode_r <= PUBS_M_NONE;
         dcnt_r <= '0;
         wide_r <= 1'b0;
         phase_r <= 2'h0;
         hold_r <= '0;
         low_r <= '0;
         acnt_r <= '0;
         skip_r <= 1'b0;
         drop_r <= 1'b0;
         mp_r <= 1'b0;
         id_r <= '0;
         addr_r <= '0;
         we_r <= 1'b0;
         waddr_r <= '0;
         wdata_r <= '0;
         alen_r <= `PUBS_SPI_ALEN_NONE;
         cmd_r <= '0;
         vti_r <= 1'b0;
         rom_r <= 1'b0;
         pre_r <= 1'b1;
         start_r <= 1'b0;
         pc_r <= '0;
         done_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         mode_r <= mode_nxt;
         dcnt_r <= dcnt_nxt;
         wide_r <= wide_nxt;
         phase_r <= phase_nxt;
         hold_r <= hold_nxt;
         low_r <= low_nxt;
         acnt_r <= acnt_nxt;
         skip_r <= skip_nxt;
         drop_r <= drop_nxt;
         mp_r <= mp_nxt;
         id_r <= id_nxt;
         addr_r <= addr_nxt;
         we_r <= we_nxt;
         waddr_r <= waddr_nxt;
         wdata_r <= wdata_nxt;
         alen_r <= alen_nxt;
         cmd_r <= cmd_nxt;
         vti_r <= vti_nxt;
         rom_r <= rom_nxt;
         pre_r <= pre_nxt;
         start_r <= start_nxt;
         pc_r <= pc_nxt;
         done_r <= done_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign mem_wr_en = we_r;
   assign mem_wr_addr = waddr_r;
   assign mem_wr_data = wdata_r;
   assign boot_mode = mode_r;
   assign dma_count = dcnt_r;
   assign dma_wide = wide_r;
   assign spi_addr_len = alen_r;
   assign spi_cmd_word = cmd_r;
   assign vector_table_internal = vti_r;
   assign rom_fetch = rom_r;
   assign peripheral_routing_en = pre_r;
   assign core_start = start_r;
   assign core_pc = pc_r;
   assign boot_done = done_r;

endmodule : pubs_boot

// [src/pubs_defs.svh]
`ifndef PUBS_DEFS_SVH
`define PUBS_DEFS_SVH

// ----------------------------------------------------------------------
// Boot selection codes
// ----------------------------------------------------------------------
`define PUBS_SEL_SPI_SLAVE 3'h0
`define PUBS_SEL_SPI_MASTER 3'h1
`define PUBS_SEL_PROM 3'h2
`define PUBS_SEL_NONE 3'h3
`define PUBS_SEL_LINK0 3'h4

// ----------------------------------------------------------------------
// Kernel transfer counts
// ----------------------------------------------------------------------
`define PUBS_KERN_CNT32 9'h180
`define PUBS_KERN_CNT48 9'h100

// ----------------------------------------------------------------------
// Memory map per variant
// ----------------------------------------------------------------------
`define PUBS_BASE_V0 20'h80000
`define PUBS_BASE_V1 20'h90000
`define PUBS_BASE_V2 20'h8c000
`define PUBS_VEC_OFF 20'h00004
`define PUBS_ROM_VEC 20'h00000

// ----------------------------------------------------------------------
// SPI master read command and address lengths in bytes
// ----------------------------------------------------------------------
`define PUBS_SPI_RD_CMD 32'h03000000
`define PUBS_SPI_ALEN_NONE 2'h0
`define PUBS_SPI_ALEN_16 2'h2
`define PUBS_SPI_ALEN_24 2'h3

// ----------------------------------------------------------------------
// Application block header fields
// ----------------------------------------------------------------------
`define PUBS_HDR_CNT_LSB 0
`define PUBS_HDR_CNT_MSB 15
`define PUBS_HDR_ID_LSB 16
`define PUBS_HDR_ID_MSB 18

`endif

// [src/pubs_pkg.sv]
package pubs_pkg;

   // ----------------------------------------------------------------------
   // Boot modes and sequencer states
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      PUBS_M_SPI_SLAVE,
      PUBS_M_SPI_MASTER,
      PUBS_M_PROM,
      PUBS_M_NONE,
      PUBS_M_LINK
   } pubs_mode_t;

   typedef enum logic [2:0] {
      PUBS_S_SAMPLE,
      PUBS_S_KERNEL,
      PUBS_S_APP_HDR,
      PUBS_S_APP_DATA,
      PUBS_S_START,
      PUBS_S_RUN
   } pubs_state_t;

   typedef enum logic [1:0] {
      PUBS_K_NOADDR,
      PUBS_K_ADDR16,
      PUBS_K_ADDR24
   } pubs_spi_kind_t;

endpackage : pubs_pkg

// [src/pubs_fifo.sv]
`timescale 1ns/100ps

module pubs_fifo #(
   parameter int WIDTH = 48,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [AW:0] cnt_r, cnt_nxt;
   logic rdy_r, rdy_nxt;
   logic push, pop;

   // ----------------------------------------------------------------------
   // Pointers and level
   // ----------------------------------------------------------------------
   // Ready is kept in its own flop so the source sees a clean register, not a gate.
   always_comb begin
      push = in_valid & rdy_r;
      pop = out_valid & out_ready;
      wp_nxt = push ? AW'(wp_r + 1'b1) : wp_r;
      rp_nxt = pop ? AW'(rp_r + 1'b1) : rp_r;
      cnt_nxt = cnt_r;
      if (push & ~pop) begin
         cnt_nxt = (AW+1)'(cnt_r + 1'b1);
      end else if (pop & ~push) begin
         cnt_nxt = (AW+1)'(cnt_r - 1'b1);
      end
      rdy_nxt = (cnt_nxt != (AW+1)'(DEPTH));
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
         rdy_r <= 1'b1;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
         rdy_r <= rdy_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wp_r] <= in_data;
      end
   end

   assign in_ready = rdy_r;
   assign out_valid = (cnt_r != '0);
   assign out_data = mem_r[rp_r];

endmodule : pubs_fifo

// [testbench/pubs_boot_assertions.sv]
`timescale 1ns/100ps
`include "pubs_defs.svh"

module pubs_boot_chk
   import pubs_pkg::*;
#(
   parameter int VARIANT = 2
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Watched outputs
   input wire logic mem_wr_en,
   input wire logic [19:0] mem_wr_addr,
   input wire logic [2:0] boot_mode,
   input wire logic [8:0] dma_count,
   input wire logic dma_wide,
   input wire logic [31:0] spi_cmd_word,
   input wire logic vector_table_internal,
   input wire logic rom_fetch,
   input wire logic peripheral_routing_en,
   input wire logic core_start,
   input wire logic [19:0] core_pc,
   input wire logic boot_done
);
   localparam logic [19:0] BASE = VARIANT == 0 ? `PUBS_BASE_V0 : VARIANT == 1 ? `PUBS_BASE_V1 : `PUBS_BASE_V2;
   logic seen_wr_r;
   logic seen_wr_nxt;

   // ----------
   // Helper
   // ----------
   // Remembers whether any memory write has been made since reset ended.
   always_comb begin
      seen_wr_nxt = nrst ? (seen_wr_r | mem_wr_en) : 1'b0;
   end
   always_ff @(posedge clk) begin
      seen_wr_r <= seen_wr_nxt;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   a_route_enabled: assert property (peripheral_routing_en) else $error("routing pins off");
   a_nob_rom: assert property (rom_fetch |-> boot_mode == 3'h3 && core_pc == `PUBS_ROM_VEC
      && !vector_table_internal && !mem_wr_en) else $error("no-boot state wrong");
   a_ext_ivt: assert property (boot_done && boot_mode != 3'h3 |-> vector_table_internal && !rom_fetch)
      else $error("vector table not internal");
   a_start_vec: assert property (core_start && !rom_fetch |-> core_pc == BASE + `PUBS_VEC_OFF)
      else $error("start address wrong");
   a_first_write: assert property (mem_wr_en && !seen_wr_r |-> mem_wr_addr == BASE)
      else $error("first write off base");
   a_kernel_size: assert property ($rose(nrst) |=> dma_wide == (boot_mode == 3'h4) && (boot_mode == 3'h3
      || dma_count == (dma_wide ? `PUBS_KERN_CNT48 : `PUBS_KERN_CNT32))) else $error("kernel count wrong");
   a_mode_latched: assert property ($past(nrst) && $past(nrst, 2) |-> $stable(boot_mode)
      && $stable(spi_cmd_word)) else $error("mode changed after latch");
   a_start_pulse: assert property (core_start |-> boot_done ##1 !core_start && boot_done)
      else $error("start pulse wrong");

   c_noboot: cover property (core_start && rom_fetch);
   c_link: cover property (core_start && dma_wide);
   c_spi: cover property (core_start && boot_mode == 3'h1);
endmodule : pubs_boot_chk

bind pubs_boot pubs_boot_chk #(.VARIANT(VARIANT)) u_chk (
   .clk(clk), .nrst(nrst), .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr), .boot_mode(boot_mode),
   .dma_count(dma_count), .dma_wide(dma_wide), .spi_cmd_word(spi_cmd_word),
   .vector_table_internal(vector_table_internal), .rom_fetch(rom_fetch),
   .peripheral_routing_en(peripheral_routing_en), .core_start(core_start), .core_pc(core_pc), .boot_done(boot_done)
);

// [testbench/pubs_src.sv]
`timescale 1ns/100ps

module pubs_src (
   // Clock
   input wire logic clk,
   // Boot stream
   output logic stream_valid,
   input wire logic stream_ready,
   output logic [47:0] stream_data
);
   logic [47:0] q [$];
   logic [47:0] last_r = 48'h0;
   int gap = 0;
   int hold = 0;
   logic taken;

   initial begin
      stream_valid = 1'b0;
      stream_data = 48'h0;
   end

   task automatic put(input logic [47:0] w);
      q.push_back(w);
   endtask : put

   // A word holds until an edge takes it; idle lines show the inverse so stale data never looks valid.
   always @(posedge clk) begin
      taken = stream_valid && stream_ready;
      #2;
      if (taken) begin
         last_r = q.pop_front();
         hold = gap;
      end else if (hold > 0) begin
         hold = hold - 1;
      end
      if (q.size() != 0 && hold == 0) begin
         stream_valid = 1'b1;
         stream_data = q[0];
      end else begin
         stream_valid = 1'b0;
         stream_data = ~last_r;
      end
   end
endmodule : pubs_src

// [testbench/test_pubs_boot.sv]
`timescale 1ns/100ps
`include "pubs_defs.svh"

module test_pubs_boot;
   localparam logic [19:0] BASE = `PUBS_BASE_V2;
   localparam logic [47:0] P0 = 48'h444411112222;
   localparam logic [47:0] P1 = 48'h555566663333;
   logic clk;
   logic nrst;
   logic [1:0] sel_n;
   logic [2:0] sel_w;
   logic [1:0] kind;
   logic mp;
   logic [2:0] pid;
   logic stream_valid, stream_ready, mem_wr_en, dma_wide, vti, rom_fetch, route_en, core_start, boot_done;
   logic [47:0] stream_data, mem_wr_data;
   logic [19:0] mem_wr_addr, core_pc;
   logic [2:0] boot_mode;
   logic [8:0] dma_count;
   logic [1:0] spi_addr_len;
   logic [31:0] spi_cmd_word;
   logic [47:0] img [logic [19:0]];
   int wr_n = 0;
   int starts = 0;
   int err_total = 0;
   int check_count = 0;

   always #12.5 clk = ~clk;

   pubs_boot dut (
      .clk(clk), .nrst(nrst), .boot_select_pins(sel_n), .boot_select_pins_wide(sel_w),
      .spi_slave_kind(kind), .mp_boot_en(mp), .proc_id(pid),
      .stream_valid(stream_valid), .stream_ready(stream_ready), .stream_data(stream_data),
      .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
      .boot_mode(boot_mode), .dma_count(dma_count), .dma_wide(dma_wide), .spi_addr_len(spi_addr_len),
      .spi_cmd_word(spi_cmd_word), .vector_table_internal(vti), .rom_fetch(rom_fetch),
      .peripheral_routing_en(route_en), .core_start(core_start), .core_pc(core_pc), .boot_done(boot_done)
   );
   pubs_src src (.clk(clk), .stream_valid(stream_valid), .stream_ready(stream_ready), .stream_data(stream_data));

   always @(posedge clk) begin
      if (mem_wr_en === 1'b1) begin
         img[mem_wr_addr] = mem_wr_data;
         wr_n++;
      end
      if (core_start === 1'b1) starts++;
   end

   task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic boot(input logic [2:0] c, input logic [1:0] k, input logic m, input logic [2:0] p);
      sel_w = c;
      sel_n = c[1:0];
      kind = k;
      mp = m;
      pid = p;
      nrst = 1'b0;
      repeat (12) @(posedge clk);
      #2;
      nrst = 1'b1;
      img.delete();
      wr_n = 0;
      starts = 0;
      @(posedge clk);
      #2;
   endtask : boot

   task automatic wait_done();
      int n = 0;
      while (boot_done !== 1'b1 && n < 3000) begin
         @(posedge clk);
         #2;
         n++;
      end
      check("boot_done", boot_done, 1'b1);
      repeat (2) @(posedge clk);
      #2;
   endtask : wait_done

   task automatic push32(input int n, input logic [31:0] w0);
      for (int i = 0; i < n; i++) src.put({16'h0, w0 + 32'(i)});
   endtask : push32

   task automatic own_blk(input logic [47:0] hdr);
      src.put(hdr);
      src.put(48'h11112222);
      src.put(48'h33334444);
      src.put(48'h55556666);
   endtask : own_blk

   task automatic test_modes();
      logic [2:0] cd [7] = '{3'h0, 3'h1, 3'h1, 3'h1, 3'h1, 3'h2, 3'h4};
      logic [1:0] kd [7] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h0};
      logic [1:0] al [7] = '{2'h0, 2'h0, 2'h2, 2'h3, 2'h0, 2'h0, 2'h0};
      for (int i = 0; i < 7; i++) begin
         boot(cd[i], kd[i], 1'b0, 3'h0);
         sel_w = ~cd[i];
         kind = ~kd[i];
         repeat (2) @(posedge clk);
         #2;
         check("boot_mode", boot_mode, cd[i]);
         check("dma_count", dma_count, cd[i] == 3'h4 ? 9'h100 : 9'h180);
         check("dma_wide", dma_wide, cd[i] == 3'h4);
         check("spi_addr_len", spi_addr_len, al[i]);
         check("spi_cmd_word", spi_cmd_word, cd[i] == 3'h1 ? `PUBS_SPI_RD_CMD : 32'h0);
         check("vector_table_internal", vti, 1'b1);
         check("rom_fetch", rom_fetch, 1'b0);
      end
      $display("test_modes done");
   endtask : test_modes

   task automatic test_noboot();
      for (int i = 0; i < 4; i++) begin
         boot(i == 0 ? 3'h3 : 3'(i + 4), 2'h0, 1'b0, 3'h0);
         repeat (3) @(posedge clk);
         #2;
         check("rom_fetch", rom_fetch, 1'b1);
         check("core_pc", core_pc, `PUBS_ROM_VEC);
         check("starts", starts, 1);
         check("writes", wr_n, 0);
         check("vector_table_internal", vti, 1'b0);
      end
      $display("test_noboot done");
   endtask : test_noboot

   task automatic test_link();
      boot(3'h4, 2'h0, 1'b0, 3'h0);
      src.gap = 1;
      for (int i = 0; i < 256; i++) src.put({28'h5a5a5a5, 20'(i)});
      src.put(48'h0);
      wait_done();
      src.gap = 0;
      check("writes", wr_n, 256);
      check("first", img[BASE], 48'h5a5a5a500000);
      check("last", img[BASE + 20'hff], 48'h5a5a5a5000ff);
      check("core_pc", core_pc, BASE + `PUBS_VEC_OFF);
      check("starts", starts, 1);
      $display("test_link done");
   endtask : test_link

   task automatic check_app(input logic [31:0] w0);
      logic [31:0] a;
      a = w0 + 32'h17e;
      check("writes", wr_n, 258);
      check("app0", img[BASE], P0);
      check("app1", img[BASE + 20'h1], P1);
      check("kern2", img[BASE + 20'h2], {w0[15:0] + 16'h4, w0 + 32'h3});
      check("kern255", img[BASE + 20'hff], {w0 + 32'h17f, a[31:16]});
      check("core_pc", core_pc, BASE + `PUBS_VEC_OFF);
      check("vector_table_internal", vti, 1'b1);
   endtask : check_app

   task automatic test_spi();
      boot(3'h1, 2'h2, 1'b0, 3'h0);
      src.put(48'hdeadbeef);
      push32(384, 32'hc0de0000);
      own_blk(48'h2);
      src.put(48'h0);
      wait_done();
      check_app(32'hc0de0000);
      $display("test_spi done");
   endtask : test_spi

   task automatic test_mp_fifo();
      boot(3'h2, 2'h0, 1'b1, 3'h5);
      push32(384, 32'h70000000);
      src.put(48'h30002);
      push32(3, 32'hbad00000);
      own_blk(48'h50002);
      src.put(48'h50000);
      wait_done();
      check_app(32'h70000000);
      push32(17, 32'h0);
      repeat (30) @(posedge clk);
      #2;
      check("stream_ready", stream_ready, 1'b0);
      check("held", src.q.size(), 1);
      check("writes", wr_n, 258);
      nrst = 1'b0;
      @(posedge clk);
      #2;
      check("ready_rst", stream_ready, 1'b1);
      check("mode_rst", boot_mode, 3'h3);
      check("route_rst", route_en, 1'b1);
      check("done_rst", boot_done, 1'b0);
      $display("test_mp_fifo done");
   endtask : test_mp_fifo

   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : summarize

   initial begin
      clk = 1'b0;
      test_modes();
      test_noboot();
      test_link();
      test_spi();
      test_mp_fifo();
      summarize();
   end

   initial begin
      #500000;
      err_total++;
      summarize();
   end
endmodule : test_pubs_boot
